//--- hw/swr_regs.svh
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH
// ************************************************************
// Timing at the 25 MHz system clock
// ************************************************************
`define SWR_CLK_MHZ 25
`define SWR_RST_US 480
`define SWR_RST_CYC (`SWR_RST_US * `SWR_CLK_MHZ)
`define SWR_PDH_US 30
`define SWR_PDH_CYC (`SWR_PDH_US * `SWR_CLK_MHZ)
`define SWR_PDL_US 120
`define SWR_PDL_CYC (`SWR_PDL_US * `SWR_CLK_MHZ)
`define SWR_SAMPLE_US 30
`define SWR_SAMPLE_CYC (`SWR_SAMPLE_US * `SWR_CLK_MHZ)
`define SWR_INT_PULSE_US 1000
`define SWR_INT_PULSE_CYC (`SWR_INT_PULSE_US * `SWR_CLK_MHZ)
`define SWR_OSC_DIV 32768
// ************************************************************
// Control byte fields and reset value
// ************************************************************
`define SWR_CTRL_IE 7
`define SWR_CTRL_IS_HI 6
`define SWR_CTRL_IS_LO 4
`define SWR_CTRL_OSC 3
`define SWR_CTRL_OSC_ECHO 2
`define SWR_CTRL_RST 8'h00
// ************************************************************
// Commands and sequence lengths
// ************************************************************
`define SWR_CMD_READ_ROM 8'h33
`define SWR_CMD_MATCH_ROM 8'h55
`define SWR_CMD_SEARCH_ROM 8'hF0
`define SWR_CMD_SKIP_ROM 8'hCC
`define SWR_CMD_READ_CLK 8'h66
`define SWR_CMD_WRITE_CLK 8'h99
`define SWR_ID_BITS 56
`define SWR_ROM_LAST 7'h3F
`define SWR_RD_LAST 7'h27
`define SWR_WR_BYTES 3'h5
`define SWR_CRC_POLY 8'h8C
`endif

//--- hw/swr_pkg.sv
package swr_pkg;
  // Protocol states of the device
  typedef enum logic [3:0] {
    ST_HALT, ST_PDH, ST_PDL, ST_ROM_CMD, ST_ROM_READ, ST_MATCH,
    ST_SEARCH, ST_FUNC, ST_RD_CLK, ST_WR_CLK
  } swr_state_e;
  typedef struct packed {
    swr_state_e state;
    logic [1:0] phase;
    logic [6:0] idx;
    logic dq_prev;
    logic [15:0] low_cnt;
    logic rst_seen;
    logic [15:0] tmr;
    logic slot_act;
    logic [15:0] slot_cnt;
    logic [7:0] byte_sh;
    logic [31:0] rbuf;
    logic [2:0] wr_bytes;
    logic ie;
    logic [2:0] isel;
    logic osc;
    logic load;
    logic dq_oe;
    logic irq_oe;
  } swr_main_s;
  typedef struct packed {
    logic [15:0] pre_cnt;
    logic [31:0] count;
    logic sel_prev;
    logic [15:0] pulse_cnt;
    logic int_active;
  } swr_tk_s;
  typedef struct packed {
    logic [7:0] sh;
    logic [5:0] idx;
    logic done;
  } swr_crc_s;
endpackage

//--- hw/swr_tk_if.sv
`timescale 1ns/1ns
`default_nettype none
// Control and status between the protocol engine and the timekeeper
interface swr_tk_if;
  logic osc_run;
  logic int_enable;
  logic [2:0] int_sel;
  logic load;
  logic [31:0] load_val;
  logic [31:0] count;
  logic int_active;
  modport ctl (output osc_run, int_enable, int_sel, load, load_val, input count, int_active);
  modport tk (input osc_run, int_enable, int_sel, load, load_val, output count, int_active);
endinterface
`default_nettype wire

//--- hw/swr_crc8.sv
`timescale 1ns/1ns
`default_nettype none
`include "swr_regs.svh"
// Serial identity check byte, worked out once after reset
module swr_crc8 #(
  parameter int W = `SWR_ID_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Identity bits, family code in the low byte
  input wire logic [W-1:0] data,
  // Result
  output logic [7:0] crc,
  output logic done
);
  import swr_pkg::*;
  swr_crc_s r_reg, r_next;
  logic fb;
  // One bit per clock, low bit first, shifting right
  always_comb begin
    r_next = r_reg;
    fb = r_reg.sh[0] ^ data[r_reg.idx];
    if (!r_reg.done) begin
      r_next.sh = {1'b0, r_reg.sh[7:1]} ^ (fb ? `SWR_CRC_POLY : 8'h00);
      r_next.idx = r_reg.idx + 6'h01;
      if (r_reg.idx == 6'(W - 1)) begin
        r_next.done = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign crc = r_reg.sh;
  assign done = r_reg.done;
endmodule // swr_crc8
`default_nettype wire

//--- hw/swr_timekeeper.sv
`timescale 1ns/1ns
`default_nettype none
`include "swr_regs.svh"
// Seconds counter, prescaler and periodic interrupt pulse
module swr_timekeeper #(
  parameter int OSC_DIV = `SWR_OSC_DIV,
  parameter int INT_PULSE_CYC = `SWR_INT_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // One pulse per oscillator period
  input wire logic osc_pulse,
  // Engine side
  swr_tk_if.tk tk
);
  import swr_pkg::*;
  swr_tk_s r_reg, r_next;
  logic sel_bit;
  // Counter bit whose toggle period equals the interval
  function automatic logic [4:0] interval_bit(input logic [2:0] sel);
    case (sel)
      3'h0: interval_bit = 5'h00;
      3'h1: interval_bit = 5'h02;
      3'h2: interval_bit = 5'h05;
      3'h3: interval_bit = 5'h06;
      3'h4: interval_bit = 5'h0B;
      3'h5: interval_bit = 5'h0C;
      3'h6: interval_bit = 5'h10;
      default: interval_bit = 5'h11;
    endcase
  endfunction
  // Count, load and interrupt timing
  always_comb begin
    r_next = r_reg;
    sel_bit = r_reg.count[interval_bit(tk.int_sel)];
    if (tk.load) begin
      r_next.count = tk.load_val;
      r_next.pre_cnt = 16'h0000;
    end else if (tk.osc_run && osc_pulse) begin
      if (r_reg.pre_cnt == 16'(OSC_DIV - 1)) begin
        r_next.pre_cnt = 16'h0000;
        r_next.count = r_reg.count + 32'h1;
      end else begin
        r_next.pre_cnt = r_reg.pre_cnt + 16'h1;
      end
    end
    // A load or a new select that flips the bit fires at once
    r_next.sel_prev = sel_bit;
    if (sel_bit != r_reg.sel_prev && tk.int_enable) begin
      r_next.int_active = 1'b1;
      r_next.pulse_cnt = 16'(INT_PULSE_CYC - 1);
    end else if (r_reg.int_active) begin
      if (r_reg.pulse_cnt == 16'h0000) begin
        r_next.int_active = 1'b0;
      end else begin
        r_next.pulse_cnt = r_reg.pulse_cnt - 16'h1;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign tk.count = r_reg.count;
  assign tk.int_active = r_reg.int_active;
endmodule // swr_timekeeper
`default_nettype wire

//--- hw/swr_rtc_top.sv
// Contract
// - Hold 64-bit identity: family, serial, CRC
// - CRC x8+x5+x4+1, zero start, LSB first
// - Every bus byte travels LSB first
// - Clock commands only after ROM command
// - Counter runs only with oscillator on
// - Master reads a frozen snapshot buffer
// - Control: IE, interval, oscillator, zero bits
// - Oscillator bits read back running state
// - Unequal oscillator bits: bit 3 wins
// - Interval select picks one of eight periods
// - Periodic pulses only while enabled
// - 32-bit seconds counter wraps to zero
// - Access starts at control, then LSB byte
// - Read command snapshots counter at MSB
// - Read sends five bytes, then repeats
// - Reset pulse abandons a read anytime
// - Write command: control byte applies at once
// - Written counter loads at next reset
// - After write, next pulse now or later
// - Stopped oscillator keeps written value
// - Interrupt pin only pulls low
// - ROM commands 33h, 55h, F0h, CCh
// - Reset 480us; presence 15-60us after release
// - Slots timed from master's falling edge
// - Pulse may fire during control access
`timescale 1ns/1ns
`default_nettype none
`include "swr_regs.svh"
module swr_rtc_top #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // Arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_1234_5678, // Arbitrary value
  parameter int RST_CYC = `SWR_RST_CYC,
  parameter int OSC_DIV = `SWR_OSC_DIV,
  parameter int INT_PULSE_CYC = `SWR_INT_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Single-wire data line, open drain
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  // Interrupt line, open drain
  output logic irq_out,
  output logic irq_oe,
  // Oscillator tick
  input wire logic osc_pulse
);
  import swr_pkg::*;

  // ************************************************************
  // Constants at register width
  // ************************************************************
  localparam logic [15:0] RST_C = 16'(RST_CYC);
  localparam logic [15:0] PDH_C = 16'(`SWR_PDH_CYC);
  localparam logic [15:0] PDL_C = 16'(`SWR_PDL_CYC);
  localparam logic [15:0] SAMPLE_C = 16'(`SWR_SAMPLE_CYC);

  // ************************************************************
  // Sub-blocks
  // ************************************************************
  swr_main_s r_reg, r_next;
  swr_tk_if tkb ();
  logic [7:0] crc;
  logic [63:0] rom;
  logic [39:0] rd_seq;
  logic [7:0] ctrl_rd;
  logic fall, rise, listening;
  logic bit_ev, tx_en, tx_bit;
  logic [7:0] rx_byte;
  logic [1:0] lane;

  // Check byte over family and serial
  swr_crc8 #(.W(`SWR_ID_BITS)) u_crc (
    .mclk(mclk),
    .rst(rst),
    .data({SERIAL, FAMILY_CODE}),
    .crc(crc),
    .done()
  );

  swr_timekeeper #(.OSC_DIV(OSC_DIV), .INT_PULSE_CYC(INT_PULSE_CYC)) u_tk (
    .mclk(mclk),
    .rst(rst),
    .osc_pulse(osc_pulse),
    .tk(tkb.tk)
  );

  // Engine drives the timekeeper from its own registers
  assign tkb.osc_run = r_reg.osc;
  assign tkb.int_enable = r_reg.ie;
  assign tkb.int_sel = r_reg.isel;
  assign tkb.load = r_reg.load;
  assign tkb.load_val = r_reg.rbuf;

  // ************************************************************
  // Data views
  // ************************************************************
  // Identity, sent from bit 0 upward
  assign rom = {crc, SERIAL, FAMILY_CODE};
  // Oscillator reported twice, low bits tied to zero
  assign ctrl_rd = {r_reg.ie, r_reg.isel, r_reg.osc, r_reg.osc, 2'b00};
  // Control byte first, then counter from its low byte
  assign rd_seq = {r_reg.rbuf, ctrl_rd};
  assign fall = r_reg.dq_prev & ~dq_in;
  assign rise = ~r_reg.dq_prev & dq_in;
  assign rx_byte = {dq_in, r_reg.byte_sh[7:1]};
  // Byte 0 of the sequence is control, so counter lane n arrives as byte n+1
  assign lane = 2'(r_reg.wr_bytes - 3'h1);

  // Bit the device sends in the coming slot
  always_comb begin
    tx_en = 1'b0;
    tx_bit = 1'b1;
    listening = 1'b1;
    case (r_reg.state)
      ST_ROM_READ: begin
        tx_en = 1'b1;
        tx_bit = rom[r_reg.idx[5:0]];
      end
      ST_SEARCH: begin
        // Bit, then its complement, then the master's choice
        tx_en = (r_reg.phase != 2'h2);
        tx_bit = rom[r_reg.idx[5:0]] ^ r_reg.phase[0];
      end
      ST_RD_CLK: begin
        tx_en = 1'b1;
        tx_bit = rd_seq[r_reg.idx[5:0]];
      end
      ST_ROM_CMD, ST_MATCH, ST_FUNC, ST_WR_CLK: begin
        tx_en = 1'b0;
      end
      default: begin
        listening = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    r_next = r_reg;
    bit_ev = 1'b0;
    r_next.load = 1'b0;
    r_next.dq_prev = dq_in;
    // Open-drain interrupt: enable only, level fixed low
    r_next.irq_oe = tkb.int_active;
    // Length of the current low stretch, saturating
    if (dq_in) begin
      r_next.low_cnt = 16'h0000;
    end else if (r_reg.low_cnt != RST_C) begin
      r_next.low_cnt = r_reg.low_cnt + 16'h1;
    end

    // Slot engine: a master edge opens, a fixed delay samples
    if (r_reg.slot_act) begin
      r_next.slot_cnt = r_reg.slot_cnt + 16'h1;
      if (r_reg.slot_cnt == SAMPLE_C - 16'h1) begin
        bit_ev = 1'b1;
        r_next.slot_act = 1'b0;
        r_next.dq_oe = 1'b0;
      end
    end else if (fall && listening) begin
      r_next.slot_act = 1'b1;
      r_next.slot_cnt = 16'h0000;
      // A one is sent by leaving the line alone
      r_next.dq_oe = tx_en & ~tx_bit;
    end

    case (r_reg.state)
      ST_PDH: begin
        r_next.tmr = r_reg.tmr + 16'h1;
        if (r_reg.tmr == PDH_C - 16'h1) begin
          r_next.state = ST_PDL;
          r_next.tmr = 16'h0000;
          r_next.dq_oe = 1'b1;
        end
      end
      ST_PDL: begin
        r_next.tmr = r_reg.tmr + 16'h1;
        if (r_reg.tmr == PDL_C - 16'h1) begin
          r_next.state = ST_ROM_CMD;
          r_next.dq_oe = 1'b0;
          r_next.idx = 7'h00;
        end
      end
      ST_ROM_CMD: begin
        if (bit_ev) begin
          r_next.byte_sh = rx_byte;
          r_next.idx = r_reg.idx + 7'h1;
          if (r_reg.idx == 7'h07) begin
            r_next.idx = 7'h00;
            r_next.phase = 2'h0;
            case (rx_byte)
              `SWR_CMD_READ_ROM: r_next.state = ST_ROM_READ;
              `SWR_CMD_MATCH_ROM: r_next.state = ST_MATCH;
              `SWR_CMD_SEARCH_ROM: r_next.state = ST_SEARCH;
              `SWR_CMD_SKIP_ROM: r_next.state = ST_FUNC;
              default: r_next.state = ST_HALT;
            endcase
          end
        end
      end
      ST_ROM_READ: begin
        if (bit_ev) begin
          r_next.idx = r_reg.idx + 7'h1;
          if (r_reg.idx == `SWR_ROM_LAST) begin
            r_next.idx = 7'h00;
            r_next.state = ST_FUNC;
          end
        end
      end
      ST_MATCH: begin
        if (bit_ev) begin
          r_next.idx = r_reg.idx + 7'h1;
          if (dq_in != rom[r_reg.idx[5:0]]) begin
            r_next.state = ST_HALT;
          end else if (r_reg.idx == `SWR_ROM_LAST) begin
            r_next.idx = 7'h00;
            r_next.state = ST_FUNC;
          end
        end
      end
      ST_SEARCH: begin
        if (bit_ev) begin
          r_next.phase = r_reg.phase + 2'h1;
          if (r_reg.phase == 2'h2) begin
            r_next.phase = 2'h0;
            r_next.idx = r_reg.idx + 7'h1;
            // Lose the search as soon as the master takes the other branch
            if (dq_in != rom[r_reg.idx[5:0]]) begin
              r_next.state = ST_HALT;
            end else if (r_reg.idx == `SWR_ROM_LAST) begin
              r_next.idx = 7'h00;
              r_next.state = ST_FUNC;
            end
          end
        end
      end
      ST_FUNC: begin
        if (bit_ev) begin
          r_next.byte_sh = rx_byte;
          r_next.idx = r_reg.idx + 7'h1;
          if (r_reg.idx == 7'h07) begin
            r_next.idx = 7'h00;
            r_next.wr_bytes = 3'h0;
            case (rx_byte)
              `SWR_CMD_READ_CLK: begin
                // Snapshot on the command's last bit
                r_next.rbuf = tkb.count;
                r_next.state = ST_RD_CLK;
              end
              `SWR_CMD_WRITE_CLK: begin
                // Unwritten lanes keep the present time
                r_next.rbuf = tkb.count;
                r_next.state = ST_WR_CLK;
              end
              default: r_next.state = ST_HALT;
            endcase
          end
        end
      end
      ST_RD_CLK: begin
        if (bit_ev) begin
          // Wrap to the control byte, same snapshot
          r_next.idx = (r_reg.idx == `SWR_RD_LAST) ? 7'h00 : r_reg.idx + 7'h1;
        end
      end
      ST_WR_CLK: begin
        if (bit_ev) begin
          r_next.byte_sh = rx_byte;
          r_next.idx = {4'h0, r_reg.idx[2:0] + 3'h1};
          if (r_reg.idx[2:0] == 3'h7) begin
            if (r_reg.wr_bytes == 3'h0) begin
              // Control takes effect at once, bit 3 rules the oscillator
              r_next.ie = rx_byte[`SWR_CTRL_IE];
              r_next.isel = rx_byte[`SWR_CTRL_IS_HI:`SWR_CTRL_IS_LO];
              r_next.osc = rx_byte[`SWR_CTRL_OSC];
            end else if (r_reg.wr_bytes != `SWR_WR_BYTES) begin
              r_next.rbuf[{lane, 3'b000} +: 8] = rx_byte;
            end
            if (r_reg.wr_bytes != `SWR_WR_BYTES) begin
              r_next.wr_bytes = r_reg.wr_bytes + 3'h1;
            end
          end
        end
      end
      default: begin
        r_next.tmr = 16'h0000;
      end
    endcase

    // Long low: abandon everything, keep only the counter commit
    if (!dq_in && r_reg.low_cnt == RST_C - 16'h1) begin
      r_next.rst_seen = 1'b1;
      r_next.state = ST_HALT;
      r_next.slot_act = 1'b0;
      r_next.dq_oe = 1'b0;
      r_next.idx = 7'h00;
      if (r_reg.state == ST_WR_CLK && r_reg.wr_bytes > 3'h1) begin
        r_next.load = 1'b1;
      end
    end
    // Release after a reset starts the presence answer
    if (rise && r_reg.rst_seen) begin
      r_next.rst_seen = 1'b0;
      r_next.state = ST_PDH;
      r_next.tmr = 16'h0000;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= ST_HALT;
      r_reg.dq_prev <= 1'b1;
      {r_reg.ie, r_reg.isel, r_reg.osc} <= 5'(`SWR_CTRL_RST >> `SWR_CTRL_OSC);
    end else begin
      r_reg <= r_next;
    end
  end

  // Both pins only ever pull low
  assign dq_out = 1'b0;
  assign irq_out = 1'b0;
  assign dq_oe = r_reg.dq_oe;
  assign irq_oe = r_reg.irq_oe;
endmodule // swr_rtc_top
`default_nettype wire

//--- sim/swr_rtc_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Pin checks on the single-wire line and interrupt
// ****
module swr_rtc_chk #(
  parameter int RST_CYC = 200,
  parameter int INT_PULSE_CYC = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched pins
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic osc_pulse
);
  logic [15:0] hi_run, lo_run, lo_ext, oe_run, irq_run, last_lo;
  // Run lengths; 16 bits are ample for any bounded bus phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_run <= '0;
      lo_run <= '0;
      lo_ext <= '0;
      oe_run <= '0;
      irq_run <= '0;
      last_lo <= '0;
    end else begin
      hi_run <= dq_in ? hi_run + 16'h1 : 16'h0;
      lo_run <= dq_in ? 16'h0 : lo_run + 16'h1;
      lo_ext <= (dq_in || dq_oe) ? 16'h0 : lo_ext + 16'h1; // Low held by others only
      oe_run <= dq_oe ? oe_run + 16'h1 : 16'h0;
      irq_run <= irq_oe ? irq_run + 16'h1 : 16'h0;
      if (dq_in && lo_run != 16'h0) begin
        last_lo <= lo_run;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_dq_level;
    dq_out == 1'b0;
  endproperty
  a_dq_level: assert property (p_dq_level)
    else $error("data pin drives high");
  property p_irq_level;
    irq_out == 1'b0;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin drives high");
  property p_irq_min;
    $rose(irq_oe) |-> irq_oe [*8];
  endproperty
  a_irq_min: assert property (p_irq_min)
    else $error("interrupt pulse too short");
  property p_irq_len;
    $fell(irq_oe) |-> irq_run >= INT_PULSE_CYC;
  endproperty
  a_irq_len: assert property (p_irq_len)
    else $error("interrupt pulse width wrong");
  property p_hold_len;
    $fell(dq_oe) |-> (oe_run >= 740 && oe_run <= 760) || (oe_run >= 2990 && oe_run <= 3010);
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("line hold length wrong");
  property p_pres_wait;
    $rose(dq_oe) |-> hi_run < 4 || (hi_run >= 745 && hi_run <= 760);
  endproperty
  a_pres_wait: assert property (p_pres_wait)
    else $error("line pulled at wrong moment");
  property p_pres_after_rst;
    $rose(dq_oe) && hi_run > 100 |-> last_lo >= RST_CYC;
  endproperty
  a_pres_after_rst: assert property (p_pres_after_rst)
    else $error("presence without a long low");
  property p_quiet_rst;
    lo_ext == RST_CYC + 2 |-> !dq_oe [*8];
  endproperty
  a_quiet_rst: assert property (p_quiet_rst)
    else $error("line driven during bus reset");
  property p_zero_hold;
    $rose(dq_oe) && hi_run < 4 |-> ##1 (dq_oe && !dq_in) [*8];
  endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("zero bit released early");
endmodule // swr_rtc_chk
`default_nettype wire

//--- sim/swr_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Behavioural single-wire master; slots last past the 750-cycle device window
// ****
module swr_bus_master #(
  parameter int RST_CYC = 3200
) (
  // Clock
  input wire logic mclk,
  // Resolved line and our pull-down
  input wire logic line,
  output logic m_low
);
  initial m_low = 1'b0;
  // Bounded wait for release; a stuck line ends the run
  task automatic wait_high(input int lim);
    for (int n = 0; n < lim && !line; n++) @(posedge mclk);
    if (!line) begin
      swr_rtc_top_tb.mismatches++;
      swr_rtc_top_tb.tally_and_finish();
    end
  endtask
  task automatic bus_reset(output logic pres);
    @(posedge mclk);
    m_low <= 1'b1; // Low longer than the reset threshold
    repeat (RST_CYC + 20) @(posedge mclk);
    m_low <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int n = 0; n < 1500 && line; n++) @(posedge mclk);
    pres = !line;
    wait_high(4000);
    repeat (20) @(posedge mclk);
  endtask
  task automatic wr_bit(input logic b);
    @(posedge mclk);
    m_low <= 1'b1; // Every slot opens on our falling edge
    repeat (b ? 30 : 770) @(posedge mclk);
    m_low <= 1'b0;
    repeat (b ? 760 : 20) @(posedge mclk);
  endtask
  task automatic rd_bit(output logic b);
    @(posedge mclk);
    m_low <= 1'b1;
    repeat (30) @(posedge mclk);
    m_low <= 1'b0;
    repeat (370) @(posedge mclk);
    b = line;
    repeat (360) @(posedge mclk);
    wait_high(1000);
    repeat (20) @(posedge mclk);
  endtask
  task automatic wr_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) wr_bit(v[i]);
  endtask
  task automatic rd_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) rd_bit(v[i]);
  endtask
endmodule // swr_bus_master
`default_nettype wire

//--- sim/swr_rtc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module swr_rtc_top_tb;
  localparam logic [7:0] FAM = 8'h5A; // Design default, arbitrary value
  localparam logic [47:0] SER = 48'h0000_1234_5678; // Design default, arbitrary value
  // Must outlast the 3000-cycle presence low and a 770-cycle zero slot
  localparam int RST_CYC = 3200;
  logic mclk, rst, osc_pulse, osc_en, irq_d, pres, b;
  logic dq_out, dq_oe, irq_out, irq_oe, m_low;
  logic [3:0] osc_gap;
  logic [7:0] v, b0;
  logic [63:0] rom;
  int mismatches, checked, seed, irq_seen, k;
  // Pull-up unless someone pulls low
  wire logic dq_in = ~(m_low | dq_oe);
  swr_rtc_top #(.RST_CYC(RST_CYC), .OSC_DIV(4), .INT_PULSE_CYC(20)) swr_rtc_top_i (
    .mclk(mclk), .rst(rst), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .irq_out(irq_out), .irq_oe(irq_oe), .osc_pulse(osc_pulse));
  swr_bus_master swr_bus_master_i (.mclk(mclk), .line(dq_in), .m_low(m_low));
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  // Random tick spacing shakes out prescaler phase slips
  always @(posedge mclk) begin
    if (rst) begin
      irq_d <= 1'b0;
      irq_seen <= 0;
      osc_pulse <= 1'b0;
      osc_gap <= 4'h0;
    end else begin
      irq_d <= irq_oe;
      if (irq_oe && !irq_d) irq_seen <= irq_seen + 1;
      osc_pulse <= osc_en && osc_gap == 4'h0;
      osc_gap <= (osc_gap == 4'h0) ? 4'h4 + 4'($unsigned($random(seed)) % 8) : osc_gap - 4'h1;
    end
  end
  function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int j = 0; j < n; j++) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[j]) ? 8'h8C : 8'h00);
    return c;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****
  // Identity read, clock write with load, snapshot read, abort
  // ****
  initial begin
    rst = 1'b1;
    osc_en = 1'b0;
    seed = 39374;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    swr_bus_master_i.bus_reset(pres);
    check(64'(pres), 64'h1);
    swr_bus_master_i.wr_byte(8'h33);
    for (int i = 0; i < 64; i++) begin
      swr_bus_master_i.rd_bit(b);
      rom[i] = b;
    end
    check(rom, {crc_of(64'({SER, FAM}), 56), SER, FAM});
    check(64'(crc_of(rom, 64)), 64'h0);
    // Oscillator bits disagree on purpose: bit 3 set, bit 2 clear
    swr_bus_master_i.wr_byte(8'h99);
    swr_bus_master_i.wr_byte(8'h88);
    osc_en <= 1'b1;
    k = irq_seen;
    b0 = 8'($random(seed));
    swr_bus_master_i.wr_byte(b0);
    check(64'(irq_seen > k), 64'h1);
    osc_en <= 1'b0;
    swr_bus_master_i.bus_reset(pres);
    k = irq_seen;
    swr_bus_master_i.wr_byte(8'hCC);
    swr_bus_master_i.wr_byte(8'h66);
    check(64'(irq_seen - k), 64'h0);
    osc_en <= 1'b1;
    swr_bus_master_i.rd_byte(v);
    check(64'(v), 64'h8C);
    swr_bus_master_i.rd_byte(v);
    check(64'(v), 64'(b0));
    // Cut a read mid-byte; the device must still answer the next reset
    repeat (3) swr_bus_master_i.rd_bit(b);
    swr_bus_master_i.bus_reset(pres);
    check(64'(pres), 64'h1);
    tally_and_finish();
  end
endmodule // swr_rtc_top_tb
bind swr_rtc_top swr_rtc_chk #(.RST_CYC(RST_CYC), .INT_PULSE_CYC(INT_PULSE_CYC)) swr_rtc_chk_i (
  .mclk(mclk), .rst(rst), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .irq_out(irq_out), .irq_oe(irq_oe), .osc_pulse(osc_pulse));
`default_nettype wire
